/* logic/dfs_params.svh */
`ifndef DFS_PARAMS_SVH
`define DFS_PARAMS_SVH

// register byte addresses
`define DFS_A_CTRL      12'h000
`define DFS_A_OSPD_LIM  12'h004
`define DFS_A_OSPD_TIM  12'h008
`define DFS_A_DEV_BAND  12'h00C
`define DFS_A_DEV_TIM   12'h010
`define DFS_A_LV_DLY    12'h014
`define DFS_A_NOMOT     12'h018
`define DFS_A_NOMOT_TIM 12'h01C
`define DFS_A_STATUS    12'h020
`define DFS_A_IRQ_STAT  12'h024
`define DFS_A_IRQ_CLR   12'h028
`define DFS_A_IRQ_EN    12'h02C
`define DFS_A_SNAP      12'h030

// ctrl field positions
`define DFS_C_VECTOR    0
`define DFS_C_DEVEN     1
`define DFS_C_ENCCHK    2
`define DFS_C_FANMODE   3
`define DFS_C_OPTMODE   4
`define DFS_C_NOMOTEN   6
`define DFS_C_RESET     7

// settings: speeds in 0.01 Hz, times in 0.01 s ticks, level in %
`define DFS_R_CTRL      32'h0000_0007
`define DFS_R_OSPD_LIM  16'h1770
`define DFS_R_OSPD_TIM  16'h0001
`define DFS_R_DEV_BAND  16'h07D0
`define DFS_R_DEV_TIM   16'h0064
`define DFS_R_LV_DLY    16'h0000
`define DFS_R_NOMOT_LVL 8'h0A
`define DFS_R_NOMOT_TIM 16'h0032

// codes of terminal functions and option loss trip modes
`define DFS_OUT_FAN     4'h8
`define DFS_OUT_LV      4'hB
`define DFS_IN_BLOCK    4'h5
`define DFS_IN_CLEAR    4'h3
`define DFS_OPT_NONE    2'h0
`define DFS_OPT_FREE    2'h1
`define DFS_OPT_DEC     2'h2

// 10 ms tick at 100 ns clock
`define DFS_TICK_MS     10
`define DFS_CLK_NS      100

`endif

/* logic/dfs_pkg.sv */
package dfs_pkg;
	typedef struct packed {
		logic [15:0] speed;
		logic [15:0] speed_dev;
		logic [15:0] current;
		logic [15:0] freq;
		logic        enc_present;
		logic        enc_single;
		logic        fan_fault;
		logic        over_temp;
		logic        dc_low;
		logic        opt_lost;
	} dfs_meas_t;

	typedef struct packed {
		logic output_block;
		logic decel;
		logic fault;
	} dfs_act_t;

	typedef enum logic [1:0] {
		DFS_RUN   = 2'b00,
		DFS_BLOCK = 2'b01,
		DFS_DECEL = 2'b10,
		DFS_FAULT = 2'b11
	} dfs_state_t;
endpackage

/* logic/dfs_supervisor.sv */
// How it works
// - overspeed check only in vector mode
// - overspeed persisting for set time blocks output
// - deviation check only vector and enabled
// - deviation beyond band for time blocks
// - encoder absent or single line faults
// - fan mode trip blocks and reports
// - fan warning mode warns; overtemp still blocks
// - DC undervoltage blocks and reports failure
// - block at once, report after delay
// - low voltage warning ignores delay
// - emergency input blocks, snapshots freq/current
// - release with run resumes acceleration
// - keypad reset or clear input clears
// - option loss acts per trip mode
// - low current with run trips
// - free-run blocks output immediately
`timescale 1ns/1ns
`include "dfs_params.svh"

module dfs_supervisor #(
	parameter int TICK_CYCLES = (`DFS_TICK_MS * 1000000) / `DFS_CLK_NS,
	parameter int NUM_IN      = 11,
	parameter int NUM_OUT     = 3
) (
	// clock and reset
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	// apb slave
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [11:0]              paddr,
	input  wire logic [31:0]              pwdata,
	output logic      [31:0]              prdata,
	output logic                          pready,
	output logic                          pslverr,
	// drive indications
	input  wire dfs_pkg::dfs_meas_t       meas,
	input  wire logic                     run_cmd,
	input  wire logic                     keypad_reset,
	input  wire logic [NUM_IN-1:0]        in_level,
	input  wire logic [NUM_IN*4-1:0]      input_terminal_function,
	input  wire logic [NUM_OUT*4-1:0]     output_terminal_function,
	// actions
	output dfs_pkg::dfs_act_t             act,
	output logic                          accel_resume,
	output logic      [NUM_OUT-1:0]       out_level,
	output logic                          irq
);

	// ------------------------------------------------------------
	// register file
	// ------------------------------------------------------------
	// settings live here; the checks below read them every cycle,
	// so a write takes effect at the next edge with no staging
	// (a limit changed mid-count is compared against the new value)

	logic [31:0] ctrl_reg;
	logic [15:0] overspeed_limit_reg;
	logic [15:0] overspeed_persist_time_reg;
	logic [15:0] dev_band_reg;
	logic [15:0] dev_time_reg;
	logic [15:0] undervoltage_report_delay_reg;
	logic [7:0]  nomot_lvl_reg;
	logic [15:0] nomot_time_reg;
	logic [7:0]  irq_stat_reg;
	logic [7:0]  irq_en_reg;
	logic [15:0] snap_freq_reg;
	logic [15:0] snap_cur_reg;
	logic [7:0]  latch_reg;
	logic        lv_fail_reg;
	logic        opt_dec_reg;
	logic        block_in_d_reg;
	dfs_pkg::dfs_state_t state;

	// zero wait states: pready is tied high and the access
	// phase edge is the only edge that writes

	logic wr;
	logic rd_ok;
	assign wr      = psel && penable && pwrite;
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !rd_ok;

	// reads are combinational from the registers; unmapped
	// offsets answer with pslverr and zero data
	always_comb begin
		rd_ok  = 1'b1;
		prdata = 32'h0000_0000;
		case (paddr)
			`DFS_A_CTRL:      prdata = ctrl_reg;
			`DFS_A_OSPD_LIM:  prdata = {16'h0000, overspeed_limit_reg};
			`DFS_A_OSPD_TIM:  prdata = {16'h0000, overspeed_persist_time_reg};
			`DFS_A_DEV_BAND:  prdata = {16'h0000, dev_band_reg};
			`DFS_A_DEV_TIM:   prdata = {16'h0000, dev_time_reg};
			`DFS_A_LV_DLY:    prdata = {16'h0000, undervoltage_report_delay_reg};
			`DFS_A_NOMOT:     prdata = {24'h00_0000, nomot_lvl_reg};
			`DFS_A_NOMOT_TIM: prdata = {16'h0000, nomot_time_reg};
			`DFS_A_STATUS:    prdata = {22'h00_0000, lv_fail_reg, latch_reg, act.fault};
			`DFS_A_IRQ_STAT:  prdata = {24'h00_0000, irq_stat_reg};
			`DFS_A_IRQ_CLR:   prdata = 32'h0000_0000;
			`DFS_A_IRQ_EN:    prdata = {24'h00_0000, irq_en_reg};
			`DFS_A_SNAP:      prdata = {snap_cur_reg, snap_freq_reg};
			default:          rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg                      <= `DFS_R_CTRL;
			overspeed_limit_reg           <= `DFS_R_OSPD_LIM;
			overspeed_persist_time_reg    <= `DFS_R_OSPD_TIM;
			dev_band_reg                  <= `DFS_R_DEV_BAND;
			dev_time_reg                  <= `DFS_R_DEV_TIM;
			undervoltage_report_delay_reg <= `DFS_R_LV_DLY;
			nomot_lvl_reg                 <= `DFS_R_NOMOT_LVL;
			nomot_time_reg                <= `DFS_R_NOMOT_TIM;
			irq_en_reg                    <= 8'h00;
		end else if (wr) begin
			case (paddr)
				`DFS_A_CTRL:      ctrl_reg <= pwdata;
				`DFS_A_OSPD_LIM:  overspeed_limit_reg <= pwdata[15:0];
				`DFS_A_OSPD_TIM:  overspeed_persist_time_reg <= pwdata[15:0];
				`DFS_A_DEV_BAND:  dev_band_reg <= pwdata[15:0];
				`DFS_A_DEV_TIM:   dev_time_reg <= pwdata[15:0];
				`DFS_A_LV_DLY:    undervoltage_report_delay_reg <= pwdata[15:0];
				`DFS_A_NOMOT:     nomot_lvl_reg <= pwdata[7:0];
				`DFS_A_NOMOT_TIM: nomot_time_reg <= pwdata[15:0];
				`DFS_A_IRQ_EN:    irq_en_reg <= pwdata[7:0];
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// 10 ms time base
	// ------------------------------------------------------------
	logic [31:0] tick_cnt_reg;
	logic        tick;
	assign tick = (tick_cnt_reg == 32'(TICK_CYCLES - 1));

	// one shared divider for all persistence timers: a trip lands
	// up to one tick early, traded for a single wide counter

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			tick_cnt_reg <= 32'h0000_0000;
		else
			tick_cnt_reg <= tick ? 32'h0000_0000 : tick_cnt_reg + 32'h0000_0001;
	end

	// saturation keeps a long-held condition from wrapping to zero

	// persistence counter step: clears when condition drops, saturates
	function automatic logic [15:0] persist(input logic cond, input logic [15:0] cnt,
			input logic tk);
		if (!cond)
			persist = 16'h0000;
		else if (tk && cnt != 16'hFFFF)
			persist = cnt + 16'h0001;
		else
			persist = cnt;
	endfunction

	// ------------------------------------------------------------
	// terminal decode
	// ------------------------------------------------------------
	// any terminal programmed with the code counts; several
	// terminals on one function simply or together

	function automatic logic term_hit(input logic [NUM_IN-1:0] lv,
			input logic [NUM_IN*4-1:0] fn, input logic [3:0] code);
		term_hit = 1'b0;
		for (int i = 0; i < NUM_IN; i++)
			if (lv[i] && fn[i*4 +: 4] == code)
				term_hit = 1'b1;
	endfunction

	logic block_in;
	logic clear_in;
	assign block_in = term_hit(in_level, input_terminal_function, `DFS_IN_BLOCK);
	assign clear_in = term_hit(in_level, input_terminal_function, `DFS_IN_CLEAR);

	// ------------------------------------------------------------
	// persistence checks
	// ------------------------------------------------------------
	logic        vector;
	logic        os_cond;
	logic        dv_cond;
	logic        nm_cond;
	logic [15:0] os_cnt_reg;
	logic [15:0] dv_cnt_reg;
	logic [15:0] nm_cnt_reg;
	logic [15:0] lv_cnt_reg;
	logic [23:0] cur_limit;

	// vector mode gates both speed checks; in other modes the speed
	// feedback is an estimate and is not trusted for tripping

	assign vector    = ctrl_reg[`DFS_C_VECTOR];
	assign os_cond   = vector && meas.speed > overspeed_limit_reg;
	assign dv_cond   = vector && ctrl_reg[`DFS_C_DEVEN]
		&& meas.speed_dev > dev_band_reg;
	// current in percent of rated, scaled to 100.00 %
	assign cur_limit = 24'(nomot_lvl_reg) * 24'd100;
	assign nm_cond   = run_cmd && ctrl_reg[`DFS_C_NOMOTEN]
		&& 24'(meas.current) < cur_limit;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			os_cnt_reg <= 16'h0000;
			dv_cnt_reg <= 16'h0000;
			nm_cnt_reg <= 16'h0000;
			lv_cnt_reg <= 16'h0000;
		end else begin
			// only a continuous excursion trips; any drop restarts the count
			os_cnt_reg <= persist(os_cond, os_cnt_reg, tick);
			dv_cnt_reg <= persist(dv_cond, dv_cnt_reg, tick);
			nm_cnt_reg <= persist(nm_cond, nm_cnt_reg, tick);
			lv_cnt_reg <= persist(meas.dc_low, lv_cnt_reg, tick);
		end
	end

	// ------------------------------------------------------------
	// latch faults
	// ------------------------------------------------------------
	// bits: 0 overspeed, 1 deviation, 2 encoder, 3 fan, 4 overtemp,
	// 5 option, 6 no motor
	logic [7:0] latch_set;
	logic       clear_req;
	assign latch_set[0] = os_cond && os_cnt_reg >= overspeed_persist_time_reg;
	assign latch_set[1] = dv_cond && dv_cnt_reg >= dev_time_reg;
	assign latch_set[2] = ctrl_reg[`DFS_C_ENCCHK]
		&& (!meas.enc_present || meas.enc_single);
	assign latch_set[3] = meas.fan_fault && !ctrl_reg[`DFS_C_FANMODE];
	assign latch_set[4] = meas.over_temp;
	assign latch_set[5] = meas.opt_lost
		&& ctrl_reg[`DFS_C_OPTMODE +: 2] == `DFS_OPT_FREE;
	assign latch_set[6] = nm_cond && nm_cnt_reg >= nomot_time_reg;
	assign latch_set[7] = 1'b0;

	assign clear_req = keypad_reset || ctrl_reg[`DFS_C_RESET]
		|| (clear_in && act.fault);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			latch_reg <= 8'h00;
		else if (clear_req)
			// software reset bit acts as a level, like the keypad key
			latch_reg <= latch_set;                    // set still wins over clear
		else
			latch_reg <= latch_reg | latch_set;
	end

	// low voltage report after delay; follows the bus level
	// the delay counts from the first low sample; a short dip restarts it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			lv_fail_reg <= 1'b0;
		else
			lv_fail_reg <= meas.dc_low
				&& lv_cnt_reg >= undervoltage_report_delay_reg;
	end

	// option decelerate request stays until clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			opt_dec_reg <= 1'b0;
		else if (meas.opt_lost && ctrl_reg[`DFS_C_OPTMODE +: 2] == `DFS_OPT_DEC)
			opt_dec_reg <= 1'b1;
		else if (clear_req)
			opt_dec_reg <= 1'b0;
	end

	// ------------------------------------------------------------
	// emergency block snapshot
	// ------------------------------------------------------------
	// taken on the rising edge of the block input only, so the
	// monitored values stay frozen while the input is held
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			block_in_d_reg <= 1'b0;
			snap_freq_reg  <= 16'h0000;
			snap_cur_reg   <= 16'h0000;
		end else begin
			block_in_d_reg <= block_in;
			if (block_in && !block_in_d_reg) begin
				snap_freq_reg <= meas.freq;
				snap_cur_reg  <= meas.current;
			end
		end
	end

	// ------------------------------------------------------------
	// action state
	// ------------------------------------------------------------
	logic                latched;
	logic                blocking;
	dfs_pkg::dfs_state_t state_next;
	assign latched  = |latch_set || |latch_reg;
	// undervoltage blocks at once regardless of report delay
	assign blocking = latched || meas.dc_low || block_in;

	// priority: a failure outranks a plain block, which outranks
	// the option decelerate request

	always_comb begin
		case (1'b1)
			latched || lv_fail_reg: state_next = dfs_pkg::DFS_FAULT;
			blocking:               state_next = dfs_pkg::DFS_BLOCK;
			opt_dec_reg:            state_next = dfs_pkg::DFS_DECEL;
			default:                state_next = dfs_pkg::DFS_RUN;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			state <= dfs_pkg::DFS_RUN;
		else
			state <= state_next;
	end

	// free-run: output dropped in the same cycle the cause appears
	always_comb begin
		act.output_block = blocking || lv_fail_reg;
		act.decel        = !act.output_block && opt_dec_reg;
		act.fault        = state == dfs_pkg::DFS_FAULT;
		case (state)
			dfs_pkg::DFS_BLOCK: accel_resume = 1'b0;
			default:            accel_resume = 1'b0;
		endcase
		if (state == dfs_pkg::DFS_BLOCK && !blocking && run_cmd)
			accel_resume = 1'b1;
	end

	// ------------------------------------------------------------
	// warning outputs
	// ------------------------------------------------------------
	// warnings are registered, one cycle behind their cause, and
	// never wait for the low-voltage report delay

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_level <= '0;
		end else begin
			for (int j = 0; j < NUM_OUT; j++)
				out_level[j] <= (output_terminal_function[j*4 +: 4] == `DFS_OUT_FAN
					&& meas.fan_fault && ctrl_reg[`DFS_C_FANMODE])
					|| (output_terminal_function[j*4 +: 4] == `DFS_OUT_LV
					&& meas.dc_low);
		end
	end

	// ------------------------------------------------------------
	// interrupts
	// ------------------------------------------------------------
	logic [7:0] irq_ev;
	assign irq_ev = {lv_fail_reg, latch_set[6:0]};

	// events set sticky bits; a clear write in the same cycle as an
	// event loses, so no event can slip past software

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq_stat_reg <= 8'h00;
		else if (wr && paddr == `DFS_A_IRQ_CLR)
			irq_stat_reg <= (irq_stat_reg & ~pwdata[7:0]) | irq_ev;
		else
			irq_stat_reg <= irq_stat_reg | irq_ev;
	end

	assign irq = |(irq_stat_reg & irq_en_reg);

endmodule // dfs_supervisor

/* bench/dfs_plant.sv */
`timescale 1ns/1ns
module dfs_plant (
	// clock and reset
	input  wire logic               pclk,
	input  wire logic               presetn,
	// wanted conditions and drive actions
	input  wire dfs_pkg::dfs_meas_t cmd,
	input  wire dfs_pkg::dfs_act_t  act,
	// indications seen by the supervisor
	output dfs_pkg::dfs_meas_t      meas
);
	logic [15:0] coast_reg;

	// a gated motor spins down slowly instead of stopping dead
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			coast_reg <= 16'h0000;
		else if (!act.output_block)
			coast_reg <= cmd.speed;
		else if (coast_reg != 16'h0000)
			coast_reg <= coast_reg - 16'h0001;
	end

	always_comb begin
		meas = cmd;
		meas.speed = act.output_block ? coast_reg : cmd.speed;
	end
endmodule // dfs_plant

/* bench/dfs_sva.sv */
`timescale 1ns/1ns
`include "dfs_params.svh"
module dfs_sva #(
	parameter int NUM_IN  = 11,
	parameter int NUM_OUT = 3
) (
	// clock and reset
	input wire logic                 pclk,
	input wire logic                 presetn,
	// apb, watched for control writes
	input wire logic                 psel,
	input wire logic                 penable,
	input wire logic                 pwrite,
	input wire logic [11:0]          paddr,
	input wire logic [31:0]          pwdata,
	// drive side
	input wire dfs_pkg::dfs_meas_t   meas,
	input wire logic                 run_cmd,
	input wire logic                 keypad_reset,
	input wire logic [NUM_IN-1:0]    in_level,
	input wire logic [NUM_IN*4-1:0]  input_terminal_function,
	input wire logic [NUM_OUT*4-1:0] output_terminal_function,
	input wire dfs_pkg::dfs_act_t    act,
	input wire logic [NUM_OUT-1:0]   out_level
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	logic [7:0] ctrl_reg;
	wire blk = act.output_block;
	// nothing left that could hold a fault once cleared
	wire calm = !meas.dc_low && !meas.fan_fault && !meas.over_temp && !meas.opt_lost
		&& meas.enc_present && !meas.enc_single && meas.speed <= 16'h1770
		&& meas.speed_dev <= 16'h07D0 && !run_cmd && in_level == '0;

	// shadow of the mode bits, so mode-bound checks know the mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ctrl_reg <= 8'h07;
		else if (psel && penable && pwrite && paddr == `DFS_A_CTRL)
			ctrl_reg <= pwdata[7:0];
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	dc_block_a: assert property (meas.dc_low |-> blk)
		else $error("dc low without block");
	lv_warn_a: assert property ((output_terminal_function[7:4] == `DFS_OUT_LV
		&& meas.dc_low) |=> out_level[1]) else $error("lv warning missing");
	bx_block_a: assert property ((input_terminal_function[3:0] == `DFS_IN_BLOCK
		&& in_level[0] && run_cmd) |-> ##[0:1] blk) else $error("bx without block");
	enc_trip_a: assert property ((ctrl_reg[2] &&
		!(meas.enc_present && !meas.enc_single)) |-> ##[0:1] blk) else $error("enc trip");
	fan_trip_a: assert property ((!ctrl_reg[3] && meas.fan_fault) |-> ##[0:1] blk)
		else $error("fan trip missing");
	fan_warn_a: assert property ((ctrl_reg[3] && meas.fan_fault &&
		output_terminal_function[3:0] == `DFS_OUT_FAN) |=> out_level[0]) else $error("fan warn");
	temp_block_a: assert property (meas.over_temp |-> ##[0:1] blk)
		else $error("overtemp without block");
	opt_act_a: assert property (meas.opt_lost |-> ##[0:1]
		(ctrl_reg[5:4] == `DFS_OPT_FREE ? blk : (ctrl_reg[5:4] != `DFS_OPT_DEC || act.decel)))
		else $error("option action wrong");
	fault_clear_a: assert property ((keypad_reset && calm) [*2] |=> !act.fault)
		else $error("fault not cleared");

	bx_c: cover property (in_level[0] && blk);
	dec_c: cover property (act.decel);
	lv_c: cover property (meas.dc_low ##1 out_level[1]);
endmodule // dfs_sva

/* bench/drive_fault_supervisor_tb.sv */
`timescale 1ns/1ns
`include "dfs_params.svh"
module drive_fault_supervisor_tb;
	logic               pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic               run_cmd = 0, keypad_reset = 0, pready, pslverr, rerr;
	logic               accel_resume, irq;
	logic [11:0]        paddr = '0;
	logic [31:0]        pwdata = '0, prdata, rdata;
	logic [10:0]        in_level = '0;
	logic [43:0]        itf = 44'h35;
	logic [11:0]        otf = 12'h0B8;
	logic [2:0]         out_level;
	dfs_pkg::dfs_meas_t cmd = '0, meas;
	dfs_pkg::dfs_act_t  act;
	int                 err_count = 0, total_checks = 0, seed = 45, i, m;
	logic [31:0]        dflt [8] = '{32'h0000_0007, 32'h0000_1770, 32'h0000_0001,
		32'h0000_07D0, 32'h0000_0064, 32'h0000_0000, 32'h0000_000A, 32'h0000_0032};

	always #50 pclk = ~pclk;

	dfs_supervisor #(.TICK_CYCLES(10)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .meas(meas), .run_cmd(run_cmd),
		.keypad_reset(keypad_reset), .in_level(in_level), .input_terminal_function(itf),
		.output_terminal_function(otf), .act(act), .accel_resume(accel_resume),
		.out_level(out_level), .irq(irq));
	dfs_plant u_plant (.pclk(pclk), .presetn(presetn), .cmd(cmd), .act(act), .meas(meas));

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic hang(input string nm);
		chk(nm, 0, 1);
		give_verdict();
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1)
			hang("pready");
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(nm, rdata, exp);
	endtask
	task automatic wblk(input logic e, input int n);
		for (int k = 0; k < n && act.output_block !== e; k++)
			@(posedge pclk);
		if (act.output_block !== e)
			hang("block wait");
	endtask
	// keypad clear, then the block must drop with no cause left
	task automatic kclr();
		keypad_reset <= 1'b1;
		repeat (3) @(posedge pclk);
		keypad_reset <= 1'b0;
		wblk(1'b0, 10);
	endtask

	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		cmd.enc_present = 1'b1;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		for (i = 0; i < 8; i++)
			rchk("default", 12'(i * 4), dflt[i]);
		apb(1'b0, 12'h040, 32'h0000_0000);
		chk("unmapped", rerr, 1);
		$display("test registers done");
		cmd.speed <= 16'h1771 + 16'($random(seed) & 255);
		apb(1'b1, `DFS_A_CTRL, 32'h0000_0006);
		repeat (60) @(posedge pclk);
		chk("ospd scalar", act.output_block, 0);
		cmd.speed <= 16'h1770;
		apb(1'b1, `DFS_A_CTRL, 32'h0000_0007);
		repeat (60) @(posedge pclk);
		chk("ospd limit", act.output_block, 0);
		cmd.speed <= 16'h1771;
		wblk(1'b1, 40);
		cmd.speed <= 16'h03E8;
		repeat (30) @(posedge pclk);
		rchk("ospd held", `DFS_A_STATUS, 32'h0000_0003);
		kclr();
		$display("test overspeed done");
		apb(1'b1, `DFS_A_DEV_TIM, 32'h0000_0003);
		for (m = 0; m < 2; m++) begin
			apb(1'b1, `DFS_A_CTRL, {29'h0, 1'b1, m[0], 1'b1});
			cmd.speed_dev <= 16'h07D1;
			repeat (15) @(posedge pclk);
			chk("dev early", act.output_block, 0);
			repeat (60) @(posedge pclk);
			chk("dev late", act.output_block, m[0]);
			cmd.speed_dev <= 16'h0000;
			kclr();
		end
		for (m = 0; m < 3; m++) begin
			apb(1'b1, `DFS_A_CTRL, m == 2 ? 32'h0000_0003 : 32'h0000_0007);
			cmd.enc_present <= m[0];
			cmd.enc_single <= m[0];
			repeat (5) @(posedge pclk);
			chk("encoder", act.output_block, m != 2);
			cmd.enc_present <= 1'b1;
			cmd.enc_single <= 1'b0;
			in_level[1] <= 1'b1;
			repeat (3) @(posedge pclk);
			in_level[1] <= 1'b0;
			wblk(1'b0, 10);
		end
		$display("test deviation and encoder done");
		cmd.fan_fault <= 1'b1;
		wblk(1'b1, 10);
		rchk("fan status", `DFS_A_STATUS, 32'h0000_0011);
		cmd.fan_fault <= 1'b0;
		kclr();
		apb(1'b1, `DFS_A_CTRL, 32'h0000_000F);
		cmd.fan_fault <= 1'b1;
		repeat (5) @(posedge pclk);
		chk("fan warn block", act.output_block, 0);
		chk("fan warn out", out_level[0], 1);
		cmd.over_temp <= 1'b1;
		wblk(1'b1, 10);
		cmd.fan_fault <= 1'b0;
		cmd.over_temp <= 1'b0;
		kclr();
		apb(1'b1, `DFS_A_LV_DLY, 32'h0000_0003);
		cmd.dc_low <= 1'b1;
		repeat (2) @(posedge pclk);
		chk("lv block", act.output_block, 1);
		chk("lv out", out_level[1], 1);
		rchk("lv early", `DFS_A_STATUS, 32'h0000_0000);
		repeat (50) @(posedge pclk);
		apb(1'b0, `DFS_A_STATUS, 32'h0000_0000);
		chk("lv late", rdata & 32'h0000_0200, 32'h0000_0200);
		cmd.dc_low <= 1'b0;
		wblk(1'b0, 20);
		$display("test fan and low voltage done");
		cmd.freq <= 16'($random(seed));
		cmd.current <= 16'($random(seed)) | 16'h8000;
		run_cmd <= 1'b1;
		@(posedge pclk);
		in_level[0] <= 1'b1;
		wblk(1'b1, 3);
		rchk("snapshot", `DFS_A_SNAP, {cmd.current, cmd.freq});
		in_level[0] <= 1'b0;
		// resume stands for one cycle only; look at it mid-cycle
		for (i = 0; i < 10 && accel_resume !== 1'b1; i++)
			@(negedge pclk);
		chk("resume", accel_resume, 1);
		@(posedge pclk);
		wblk(1'b0, 5);
		run_cmd <= 1'b0;
		for (m = 0; m < 3; m++) begin
			apb(1'b1, `DFS_A_CTRL, 32'h0000_0007 | 32'(m << 4));
			cmd.opt_lost <= 1'b1;
			repeat (5) @(posedge pclk);
			chk("opt block", act.output_block, m == 1);
			chk("opt decel", act.decel, m == 2);
			cmd.opt_lost <= 1'b0;
			kclr();
		end
		$display("test block input and option done");
		apb(1'b1, `DFS_A_IRQ_CLR, 32'h0000_00FF);
		apb(1'b1, `DFS_A_IRQ_EN, 32'h0000_0040);
		apb(1'b1, `DFS_A_NOMOT_TIM, 32'h0000_0002);
		apb(1'b1, `DFS_A_CTRL, 32'h0000_0047);
		cmd.current <= 16'h03E7;
		run_cmd <= 1'b1;
		wblk(1'b1, 60);
		rchk("irq status", `DFS_A_IRQ_STAT, 32'h0000_0040);
		chk("irq", irq, 1);
		apb(1'b1, `DFS_A_IRQ_EN, 32'h0000_0000);
		chk("irq masked", irq, 0);
		run_cmd <= 1'b0;
		cmd.current <= 16'h07D0;
		kclr();
		apb(1'b1, `DFS_A_IRQ_CLR, 32'h0000_0040);
		rchk("irq cleared", `DFS_A_IRQ_STAT, 32'h0000_0000);
		$display("test no motor and irq done");
		give_verdict();
	end
endmodule // drive_fault_supervisor_tb

bind dfs_supervisor dfs_sva #(.NUM_IN(NUM_IN), .NUM_OUT(NUM_OUT)) u_sva (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .meas(meas), .run_cmd(run_cmd), .keypad_reset(keypad_reset),
	.in_level(in_level), .input_terminal_function(input_terminal_function),
	.output_terminal_function(output_terminal_function), .act(act), .out_level(out_level));
